// *** dv/srh_status_sva.sv ***
`default_nettype none
// Port-level checks of the status summary block
module srh_status_sva (
    input wire logic        clk_sys, rstn, msg_available, errq_push, errq_pop,
    input wire logic        static_error_no_meas, static_error_bad_result, static_error_warning,
    input wire logic        static_error_critical, legacy_locked, static_error_list_query,
    input wire logic [15:0] ques_enable, oper_enable, ques_event_q, oper_event_q,
    input wire logic [7:0]  std_event_enable, srq_enable, std_event_q, status_summary_byte,
    input wire logic [15:0] device_static_error_status,
    input wire logic [3:0]  static_error_list,
    input wire logic        static_error_list_valid, srq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    logic [1:0] ok_r;
    // Two cycles out of reset before past values count
    always_ff @(posedge clk_sys) ok_r <= {ok_r[0], rstn};
    a_dev_sum_or: assert property (device_static_error_status[0] == |device_static_error_status[4:1])
        else $error("device summary bit wrong");
    a_dev_unused_zero: assert property (device_static_error_status[15:8] == 8'h00
        && device_static_error_status[6:5] == 2'h0) else $error("unused device bits set");
    a_dev_levels: assert property (ok_r[1] |-> device_static_error_status[7:1] == {$past(legacy_locked),
        2'h0, $past(static_error_critical), $past(static_error_warning), $past(static_error_bad_result),
        $past(static_error_no_meas)}) else $error("device bits do not follow errors");
    a_mav_level: assert property (ok_r[1] |-> status_summary_byte[4] == $past(msg_available))
        else $error("message available bit wrong");
    a_ques_summary: assert property (ok_r[1] |-> status_summary_byte[3] == |(ques_event_q & $past(ques_enable)))
        else $error("questionable summary wrong");
    a_oper_summary: assert property (ok_r[1] |-> status_summary_byte[7] == |(oper_event_q & $past(oper_enable)))
        else $error("operation summary wrong");
    a_std_summary: assert property (ok_r[1] |-> status_summary_byte[5] == |(std_event_q & $past(std_event_enable)))
        else $error("standard event summary wrong");
    a_mss_summary: assert property (ok_r[1] |-> status_summary_byte[6]
        == |(status_summary_byte & 8'hbf & $past(srq_enable))) else $error("master summary wrong");
    a_srq_follows: assert property (status_summary_byte[6] && $past(status_summary_byte[6]) |-> srq)
        else $error("service request missing");
    a_list_answer: assert property (ok_r[1] |-> static_error_list_valid == $past(static_error_list_query))
        else $error("error list answer timing wrong");
    a_errq_not_empty: assert property (errq_push && !errq_pop |-> ##2 status_summary_byte[2])
        else $error("error queue bit not set");
    a_errq_request: assert property (errq_push && !errq_pop && srq_enable[2] |-> ##2 srq)
        else $error("no request for error entry");
endmodule // srh_status_sva
bind srh_status_top srh_status_sva i_sva (.*);
`default_nettype wire

// *** dv/tb_top.sv ***
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rstn, static_error_no_meas, static_error_bad_result, static_error_warning;
    logic static_error_critical, legacy_locked, msg_available, errq_push, errq_pop, dev_event_rd;
    logic oper_event_rd, ques_event_rd, std_event_rd, static_error_list_query;
    logic [15:0] oper_cond, ques_cond, dev_enable, dev_ptr, dev_ntr, oper_enable, oper_ptr;
    logic [15:0] oper_ntr, ques_enable, ques_ptr, ques_ntr;
    logic [7:0]  std_event_set, std_event_enable, srq_enable;
    wire logic [7:0]  status_summary_byte, std_event_q;
    wire logic [15:0] device_static_error_status, dev_event_q, oper_event_q, ques_event_q;
    wire logic [3:0]  static_error_list;
    wire logic        static_error_list_valid, srq, cmd_setting_blocked;
    int          miscompares = 0, checked = 0, cyc = 0;
    logic [31:0] lf;
    srh_status_top #(.ERRQ_DEPTH(2)) i_dut (.*);
    // Clock
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            miscompares++;
            finish_test;
        end
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected device word from {lock, crit, warn, badres, nomeas}
    function automatic logic [15:0] dev_exp(input logic [4:0] e);
        return {8'h00, e[4], 2'h0, e[3:0], |e[3:0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        lf = 32'h9a1e;
        rstn = 0;
        {static_error_no_meas, static_error_bad_result, static_error_warning, static_error_critical} = '0;
        {legacy_locked, msg_available, errq_push, errq_pop, dev_event_rd, oper_event_rd} = '0;
        {ques_event_rd, std_event_rd, static_error_list_query, oper_cond, ques_cond, dev_enable} = '0;
        {dev_ptr, dev_ntr, oper_enable, oper_ptr, oper_ntr, ques_enable, ques_ptr, ques_ntr} = '0;
        {std_event_set, std_event_enable, srq_enable} = '0;
        tick(16);
        rstn = 1;
        tick(1);
        chk(16'(status_summary_byte), 16'h0000);
        chk(device_static_error_status, 16'h0000);
        // Random static errors, lock and error list query
        repeat (20) begin
            lf = nx(lf);
            {legacy_locked, static_error_critical, static_error_warning, static_error_bad_result,
                static_error_no_meas} = lf[4:0];
            static_error_list_query = 1;
            tick(1);
            chk(16'(static_error_list_valid), 16'h0001);
            static_error_list_query = 0;
            tick(1);
            chk(16'(static_error_list_valid), 16'h0000);
            chk(device_static_error_status, dev_exp(lf[4:0]));
            chk(16'(static_error_list), 16'(lf[3:0]));
            chk(16'(cmd_setting_blocked), 16'(lf[4]));
        end
        // Device summary from a rising critical error
        {legacy_locked, static_error_critical, static_error_warning, static_error_bad_result} = '0;
        static_error_no_meas = 0;
        {dev_ptr, dev_enable, srq_enable} = {16'hffff, 16'hffff, 8'h02};
        tick(3);
        static_error_critical = 1;
        tick(4);
        chk(16'(status_summary_byte), 16'h0042);
        chk(dev_event_q, 16'h0011);
        chk(16'(srq), 16'h0001);
        dev_event_rd = 1;
        tick(1);
        {dev_event_rd, static_error_critical} = '0;
        tick(3);
        chk(16'(status_summary_byte), 16'h0000);
        // Questionable rising events latch until read
        {ques_ptr, ques_enable, srq_enable} = {16'hffff, 16'h0008, 8'h08};
        lf = nx(lf);
        ques_cond = lf[15:0] | 16'h0008;
        tick(3);
        chk(ques_event_q, ques_cond);
        chk(16'(status_summary_byte), 16'h0048);
        ques_event_rd = 1;
        tick(1);
        ques_event_rd = 0;
        tick(2);
        chk(ques_event_q, 16'h0000);
        chk(16'(status_summary_byte), 16'h0000);
        // Operation events on falling edges only
        {oper_ntr, oper_enable, srq_enable} = {16'hffff, 16'hffff, 8'h00};
        lf = nx(lf);
        oper_cond = lf[15:0];
        tick(3);
        chk(oper_event_q, 16'h0000);
        oper_cond = 0;
        tick(3);
        chk(oper_event_q, lf[15:0]);
        chk(16'(status_summary_byte[7]), 16'(|lf[15:0]));
        // Standard events gated by their mask
        lf = nx(lf);
        {std_event_set, std_event_enable} = lf[15:0];
        tick(1);
        std_event_set = 0;
        tick(2);
        chk(16'(std_event_q), 16'(lf[15:8]));
        chk(16'(status_summary_byte[5]), 16'(|(lf[15:8] & lf[7:0])));
        // Message available both ways
        for (int i = 0; i < 2; i++) begin
            msg_available = (i == 0);
            tick(2);
            chk(16'(status_summary_byte[4]), 16'(i == 0));
        end
        // Error queue: request per entry, overfill refused, drain
        srq_enable = 8'h04;
        errq_push = 1;
        tick(1);
        errq_push = 0;
        tick(2);
        chk(16'(status_summary_byte[2]), 16'h0001);
        chk(16'(srq), 16'h0001);
        errq_push = 1;
        tick(2);
        errq_push = 0;
        errq_pop = 1;
        tick(2);
        errq_pop = 0;
        tick(3);
        chk(16'(status_summary_byte[2]), 16'h0000);
        chk(16'(srq), 16'h0000);
        finish_test;
    end
endmodule // tb_top
`default_nettype wire

// *** hw/srh_errq_tracker.sv ***
`default_nettype none
// Error queue occupancy tracking and per-entry request pulse
module srh_errq_tracker #(
    parameter int DEPTH = 16
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic push,
    input  wire logic pop,
    output logic      not_empty,
    output logic      added
);
    localparam int CW = $clog2(DEPTH + 1);
    initial begin
        if (DEPTH < 1) $error("srh_errq_tracker: DEPTH must be positive");
    end

    logic [CW-1:0] cnt_r;
    logic          do_push;
    logic          do_pop;

    assign do_push = push && (cnt_r != CW'(DEPTH));
    assign do_pop  = pop && (cnt_r != '0);

    // Entry count
    always_ff @(posedge clk_sys) begin
        if (!rstn)                  cnt_r <= '0;
        else if (do_push && !do_pop) cnt_r <= cnt_r + 1'b1;
        else if (do_pop && !do_push) cnt_r <= cnt_r - 1'b1;
    end

    assign not_empty = (cnt_r != '0);
    assign added     = do_push;
endmodule : srh_errq_tracker
`default_nettype wire

// *** hw/srh_event_reg.sv ***
`default_nettype none
// Condition / transition filter / event latch / enable summary
module srh_event_reg #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] ptr,
    input  wire logic [W-1:0] ntr,
    input  wire logic [W-1:0] enable,
    input  wire logic         rd_clr,
    output logic      [W-1:0] event_q,
    output logic              summary
);
    initial begin
        if (W < 1 || W > 32) $error("srh_event_reg: W out of range");
    end

    logic [W-1:0] cond_prev_r;
    logic [W-1:0] hit;

    // Edges picked by transition filters
    assign hit = (cond & ~cond_prev_r & ptr) | (~cond & cond_prev_r & ntr);

    // Previous condition
    always_ff @(posedge clk_sys) begin
        if (!rstn) cond_prev_r <= '0;
        else       cond_prev_r <= cond;
    end

    // Sticky events, set wins over read clear
    always_ff @(posedge clk_sys) begin
        if (!rstn)       event_q <= '0;
        else if (rd_clr) event_q <= hit;
        else             event_q <= event_q | hit;
    end

    // Combinational summary
    assign summary = |(event_q & enable);
endmodule : srh_event_reg
`default_nettype wire

// *** hw/srh_status_top.sv ***
`default_nettype none
module srh_status_top #(
    parameter int ERRQ_DEPTH = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Static error conditions
    input  wire logic        static_error_no_meas,
    input  wire logic        static_error_bad_result,
    input  wire logic        static_error_warning,
    input  wire logic        static_error_critical,
    input  wire logic        legacy_locked,
    // Lower level summaries and conditions
    input  wire logic [15:0] oper_cond,
    input  wire logic [15:0] ques_cond,
    input  wire logic [7:0]  std_event_set,
    input  wire logic        msg_available,
    input  wire logic        errq_push,
    input  wire logic        errq_pop,
    // Configuration from command layer
    input  wire logic [15:0] dev_enable,
    input  wire logic [15:0] dev_ptr,
    input  wire logic [15:0] dev_ntr,
    input  wire logic [15:0] oper_enable,
    input  wire logic [15:0] oper_ptr,
    input  wire logic [15:0] oper_ntr,
    input  wire logic [15:0] ques_enable,
    input  wire logic [15:0] ques_ptr,
    input  wire logic [15:0] ques_ntr,
    input  wire logic [7:0]  std_event_enable,
    input  wire logic [7:0]  srq_enable,
    // Event queries: each *_event_rd clears its event register, static_error_list_query clears nothing
    input  wire logic        dev_event_rd,
    input  wire logic        oper_event_rd,
    input  wire logic        ques_event_rd,
    input  wire logic        std_event_rd,
    input  wire logic        static_error_list_query,
    // Results
    output logic [7:0]       status_summary_byte,
    output logic [15:0]      device_static_error_status,
    output logic [15:0]      dev_event_q,
    output logic [15:0]      oper_event_q,
    output logic [15:0]      ques_event_q,
    output logic [7:0]       std_event_q,
    output logic [3:0]       static_error_list,
    output logic             static_error_list_valid,
    output logic             srq,
    output logic             cmd_setting_blocked
);
    initial begin
        if (ERRQ_DEPTH < 1) $error("srh_status_top: ERRQ_DEPTH must be positive");
    end

    logic [15:0] dev_cond;
    logic [15:0] dev_ev;
    logic [15:0] oper_ev;
    logic [15:0] ques_ev;
    logic        dev_sum;
    logic        oper_sum;
    logic        ques_sum;
    logic        errq_ne;
    logic        errq_added;
    logic [7:0]  std_ev_r;
    logic [7:0]  sb;
    logic        mss;
    logic        errq_pulse_r;

    // Device condition word, unused bits held at zero
    always_comb begin
        dev_cond = srh_pkg::DEV_RST;
        dev_cond[srh_pkg::DEV_NOMEAS_BIT] = static_error_no_meas;
        dev_cond[srh_pkg::DEV_ERRRES_BIT] = static_error_bad_result;
        dev_cond[srh_pkg::DEV_WARN_BIT]   = static_error_warning;
        dev_cond[srh_pkg::DEV_CRIT_BIT]   = static_error_critical;
        dev_cond[srh_pkg::DEV_LOCK_BIT]   = legacy_locked;
        dev_cond[srh_pkg::DEV_SUM_BIT]    = static_error_no_meas | static_error_bad_result
                                          | static_error_warning | static_error_critical;
    end

    // Device status event register
    srh_event_reg #(.W(srh_pkg::EVT_W)) u_dev (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .cond    (dev_cond),
        .ptr     (dev_ptr),
        .ntr     (dev_ntr),
        .enable  (dev_enable),
        .rd_clr  (dev_event_rd),
        .event_q (dev_ev),
        .summary (dev_sum)
    );

    // Operation status event register
    srh_event_reg #(.W(srh_pkg::EVT_W)) u_oper (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .cond    (oper_cond),
        .ptr     (oper_ptr),
        .ntr     (oper_ntr),
        .enable  (oper_enable),
        .rd_clr  (oper_event_rd),
        .event_q (oper_ev),
        .summary (oper_sum)
    );

    // Questionable status event register
    srh_event_reg #(.W(srh_pkg::EVT_W)) u_ques (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .cond    (ques_cond),
        .ptr     (ques_ptr),
        .ntr     (ques_ntr),
        .enable  (ques_enable),
        .rd_clr  (ques_event_rd),
        .event_q (ques_ev),
        .summary (ques_sum)
    );

    // Error queue occupancy
    srh_errq_tracker #(.DEPTH(ERRQ_DEPTH)) u_errq (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .push      (errq_push),
        .pop       (errq_pop),
        .not_empty (errq_ne),
        .added     (errq_added)
    );

    // Standard event register, new events win over read clear
    always_ff @(posedge clk_sys) begin
        if (!rstn)             std_ev_r <= srh_pkg::SB_RST;
        else if (std_event_rd) std_ev_r <= std_event_set;
        else                   std_ev_r <= std_ev_r | std_event_set;
    end

    // Status byte assembly
    always_comb begin
        sb = srh_pkg::SB_RST;
        sb[srh_pkg::SB_DEV_BIT]  = dev_sum;
        sb[srh_pkg::SB_ERRQ_BIT] = errq_ne;
        sb[srh_pkg::SB_QUES_BIT] = ques_sum;
        sb[srh_pkg::SB_MAV_BIT]  = msg_available;
        sb[srh_pkg::SB_ESB_BIT]  = |(std_ev_r & std_event_enable);
        sb[srh_pkg::SB_OPER_BIT] = oper_sum;
        mss = |(sb & srq_enable & ~(8'h01 << srh_pkg::SB_MSS_BIT));
        sb[srh_pkg::SB_MSS_BIT]  = mss;
    end

    // Error queue entry pulse raises request for one cycle when the queue bit is enabled in srq_enable
    always_ff @(posedge clk_sys) begin
        if (!rstn) errq_pulse_r <= 1'b0;
        else       errq_pulse_r <= errq_added && srq_enable[srh_pkg::SB_ERRQ_BIT];
    end

    // Registered outputs
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            status_summary_byte        <= srh_pkg::SB_RST;
            device_static_error_status <= srh_pkg::DEV_RST;
            dev_event_q                <= srh_pkg::DEV_RST;
            oper_event_q               <= srh_pkg::DEV_RST;
            ques_event_q               <= srh_pkg::DEV_RST;
            std_event_q                <= srh_pkg::SB_RST;
            srq                        <= 1'b0;
            cmd_setting_blocked        <= 1'b0;
        end else begin
            status_summary_byte        <= sb;
            device_static_error_status <= dev_cond;
            dev_event_q                <= dev_ev;
            oper_event_q               <= oper_ev;
            ques_event_q               <= ques_ev;
            std_event_q                <= std_ev_r;
            srq                        <= mss || errq_pulse_r;
            cmd_setting_blocked        <= legacy_locked;
        end
    end

    // Static error list query answer
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            static_error_list       <= 4'h0;
            static_error_list_valid <= 1'b0;
        end else begin
            static_error_list_valid <= static_error_list_query;
            if (static_error_list_query)
                static_error_list <= {static_error_critical, static_error_warning,
                                      static_error_bad_result, static_error_no_meas};
        end
    end
endmodule : srh_status_top
`default_nettype wire

// *** pkg/srh_pkg.sv ***
`default_nettype none
package srh_pkg;
    // Status byte bit positions
    localparam int SB_DEV_BIT  = 1;
    localparam int SB_ERRQ_BIT = 2;
    localparam int SB_QUES_BIT = 3;
    localparam int SB_MAV_BIT  = 4;
    localparam int SB_ESB_BIT  = 5;
    localparam int SB_MSS_BIT  = 6;
    localparam int SB_OPER_BIT = 7;
    // Device status bit positions
    localparam int DEV_SUM_BIT    = 0;
    localparam int DEV_NOMEAS_BIT = 1;
    localparam int DEV_ERRRES_BIT = 2;
    localparam int DEV_WARN_BIT   = 3;
    localparam int DEV_CRIT_BIT   = 4;
    localparam int DEV_LOCK_BIT   = 7;
    // Widths and reset values
    localparam int SB_W  = 8;
    localparam int DEV_W = 16;
    localparam int EVT_W = 16;
    localparam logic [7:0]  SB_RST  = 8'h00;
    localparam logic [15:0] DEV_RST = 16'h0000;
    localparam logic [15:0] EN_RST  = 16'h0000;
    localparam logic [15:0] TR_RST  = 16'hffff;
    // Event register read path select
    typedef enum logic [1:0] {
        SRH_RD_IDLE = 2'b00,
        SRH_RD_HOLD = 2'b01
    } srh_rd_type;
endpackage : srh_pkg
`default_nettype wire
